// >>> pkg/clkdiv_defs.svh
// register offsets, field positions, reset values and counts for the codec clock divider
//
// Function
// - mode bit set selects 272 cycles per sample, clear selects 256; resets clear
// - adc rate divider code: /1 /1.5 /2 /3 /4 /5.5 /6, 111 reserved, resets 000
// - dac rate divider uses the same encoding, independent, resets to divide by one
// - bit clock divider 4-bit code from /1 up to /24, codes 1101..1111 give /32
// - master bit set: device makes bit clock and drives pin; clear: pin input
// - bit clock slave: bit clock comes from the host, not generated inside
// - adc bit clock on alternate pin runs at the shared bit clock rate in master mode, stays low in slave
// - frame clock toggles after 11-bit count of bit clocks, reset 64, below 8 invalid
// - adc frame enable bit 11 turns on adc frame generation, resets off
// - dac frame enable bit 11 turns on dac frame generation, resets off
// - a frame clock whose frame enable is off is an input from the host, in master and slave mode alike
// - frame pin carries dac frame when select is 0, adc frame when 1
// - output clock divider code: /1 /2 /3 /4 /5.5 /6, 110 and 111 reserved
// - slow clock enable is one bit reachable at two register addresses
// - slow clock rate bit picks divide by 2^21 when 0, 2^19 when 1
// - enabled slow clock times both jack debounce and zero-cross timeout
// - master bit and frame clock edges sit at repeatable positions for settings
`ifndef CLKDIV_DEFS_SVH
`define CLKDIV_DEFS_SVH

`define REG_POWER_MGMT_FOUR    8'h0b
`define REG_CLOCK_CONTROL_ONE  8'h28
`define REG_CLOCK_CONTROL_TWO  8'h29
`define REG_DAC_CONTROL        8'h30
`define REG_DAC_FRAME_RATE     8'h35
`define REG_DAC_CLOCK_CONTROL  8'h36
`define REG_ADC_CLOCK_CONTROL  8'h44
`define REG_ADC_FRAME_RATE     8'h46
`define REG_AUDIO_IF_DAC_CTRL  8'h73

`define BIT_SLOWCLK_EN_PM4     8
`define BIT_SLOWCLK_EN_CC1     15
`define BIT_SLOWCLK_RATE       14
`define BCLK_DIV_MSB           7
`define BCLK_DIV_LSB           4
`define OUTCLK_DIV_MSB         2
`define RATE_DIV_MSB           2
`define BIT_FRAME_SRC_SEL      15
`define BIT_CLOCKING_MODE      12
`define BIT_FRAME_GEN_EN       11
`define FRAME_LEN_MSB          10
`define BIT_BITCLK_MASTER      14

`define FRAME_LEN_RST          11'h040
`define FRAME_LEN_MIN          11'h008
`define SMP_LEN_NORMAL         9'h100
`define SMP_LEN_USB            9'h110
`define SLOW_DIV_LONG          2097152
`define SLOW_DIV_SHORT         524288

`endif

// >>> pkg/clkdiv_pkg.sv
// types shared by the codec clock divider modules
package clkdiv_pkg;

  typedef enum logic {
    MODE_NORMAL = 1'b0,
    MODE_USB    = 1'b1
  } clk_mode_t;

  typedef enum logic {
    PHASE_LOW  = 1'b0,
    PHASE_HIGH = 1'b1
  } frame_phase_t;

  typedef struct packed {
    logic [5:0] cnt;
    logic       alt;
    logic       level;
  } div_state_t;

  typedef struct packed {
    logic [10:0]  cnt;
    frame_phase_t phase;
  } frame_state_t;

  typedef struct packed {
    logic        slowclk_en;
    logic        slowclk_rate_sel;
    logic [3:0]  bclk_div;
    logic [2:0]  outclk_div;
    logic        frame_pin_src_sel;
    clk_mode_t   clocking_mode_sel;
    logic [10:0] dac_frame_len;
    logic        dac_frame_gen_en;
    logic [10:0] adc_frame_len;
    logic        adc_frame_gen_en;
    logic [2:0]  dac_rate_div;
    logic [2:0]  adc_rate_div;
    logic        bitclk_master_en;
    logic [15:0] rdata;
    logic [2:0]  bclk_sync;
    logic [1:0]  dac_frame_sync;
    logic [1:0]  adc_frame_sync;
    logic [8:0]  adc_smp_cnt;
    logic [8:0]  dac_smp_cnt;
    logic [20:0] slow_cnt;
  } top_state_t;

endpackage

// >>> rtl/frac_div.sv
// divider with half-integer ratios, giving a tick and a level clock
`timescale 1ns/100ps
module frac_div (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // control: run low stops and clears the divider; ratio times two
  input  wire logic       run,
  input  wire logic [6:0] ratio_x2,
  // outputs
  output logic            tick,
  output logic            level
);
  clkdiv_pkg::div_state_t st_reg;
  clkdiv_pkg::div_state_t st_next;
  logic [5:0]             base;
  logic [5:0]             cur_len;
  logic [5:0]             half_len;

  // odd ratio_x2 alternates base and base+1 periods
  // >= ends a period at once when the ratio shrinks below the running count
  assign base     = ratio_x2[6:1];
  assign cur_len  = base + {5'h00, ratio_x2[0] & st_reg.alt};
  assign half_len = 6'((7'(cur_len) + 7'h01) >> 1);
  assign tick     = run && (st_reg.cnt >= cur_len - 6'h01);
  assign level    = st_reg.level;

  // counter; clearing while stopped keeps edge positions repeatable
  always_comb begin
    st_next = st_reg;
    if (!run) begin
      st_next = '0;
    end else if (tick) begin
      st_next.cnt = 6'h00;
      st_next.alt = ~st_reg.alt;
    end else begin
      st_next.cnt = st_reg.cnt + 6'h01;
    end
    st_next.level = run && (st_next.cnt < half_len);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_half_alternate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (run && $stable(ratio_x2) && ratio_x2 == 7'h03 && tick && $past(tick))
      |=> !tick ##1 tick)
    else $error("ratio 1.5 did not alternate one and two cycle periods");

  a_whole_period: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (run && ratio_x2 == 7'h08 && tick) ##1 (run && ratio_x2 == 7'h08)[*3]
      |=> tick)
    else $error("ratio 4 did not repeat every four cycles");
endmodule // frac_div

// >>> rtl/frame_gen.sv
// frame clock generator counting bit clocks per phase
`timescale 1ns/100ps
`include "clkdiv_defs.svh"
module frame_gen (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // control
  input  wire logic        gen_en,
  input  wire logic        bit_tick,
  input  wire logic [10:0] phase_len,
  // output
  output logic             frame_clk
);
  clkdiv_pkg::frame_state_t st_reg;
  clkdiv_pkg::frame_state_t st_next;
  logic                     active;

  // lengths below the minimum are invalid and hold the generator idle
  assign active    = gen_en && (phase_len >= `FRAME_LEN_MIN);
  assign frame_clk = (st_reg.phase == clkdiv_pkg::PHASE_HIGH);

  // toggle after phase_len bit clocks: one frame is two phases
  // a shortened length ends the phase at once instead of wrapping the count
  always_comb begin
    st_next = st_reg;
    if (!active) begin
      st_next = '0;
    end else if (bit_tick) begin
      if (st_reg.cnt >= phase_len - 11'h001) begin
        st_next.cnt = 11'h000;
        unique case (st_reg.phase)
          clkdiv_pkg::PHASE_LOW:  st_next.phase = clkdiv_pkg::PHASE_HIGH;
          clkdiv_pkg::PHASE_HIGH: st_next.phase = clkdiv_pkg::PHASE_LOW;
        endcase
      end else begin
        st_next.cnt = st_reg.cnt + 11'h001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_frame_on_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(active) && active && $changed(frame_clk)) |-> $past(bit_tick))
    else $error("frame clock moved without a bit clock tick");

  a_frame_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !active |=> !frame_clk)
    else $error("frame clock not low while generation is off");
endmodule // frame_gen

// >>> rtl/audio_clock_divider_gen.sv
// codec clock divider: sample rate, bit, frame, output and slow clocks
`timescale 1ns/100ps
`include "clkdiv_defs.svh"
module audio_clock_divider_gen #(
  parameter int unsigned SLOW_DIV_LONG  = `SLOW_DIV_LONG,
  parameter int unsigned SLOW_DIV_SHORT = `SLOW_DIV_SHORT
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // bit clock pin
  input  wire logic        bitclk_pin_in,
  output logic             bitclk_pin_out,
  output logic             bitclk_pin_oe,
  // shared frame pin
  input  wire logic        frame_pin_in,
  output logic             frame_pin_out,
  output logic             frame_pin_oe,
  // alternate pins
  input  wire logic        adc_frame_pin_in,
  output logic             adc_bit_clock,
  output logic             codec_out_clock,
  // clocks and ticks to the codec core
  output logic             bitclk_tick,
  output logic             adc_frame_clock,
  output logic             dac_frame_clock,
  output logic             adc_rate_tick,
  output logic             dac_rate_tick,
  output logic             adc_sample_tick,
  output logic             dac_sample_tick,
  output logic             outclk_tick,
  output logic             jack_debounce_tick,
  output logic             zc_timeout_tick
);
  clkdiv_pkg::top_state_t st_reg;
  clkdiv_pkg::top_state_t st_next;
  logic [6:0]             adc_x2;
  logic [6:0]             dac_x2;
  logic [6:0]             bclk_x2;
  logic [6:0]             out_x2;
  logic                   bclk_gen_tick;
  logic                   bclk_gen_level;
  logic                   out_level;
  logic                   adc_gen_clk;
  logic                   dac_gen_clk;
  logic                   slave_bit_tick;
  logic [8:0]             smp_len;
  logic [20:0]            slow_limit;
  logic                   slow_tick;

  // sample rate code to ratio times two, zero for reserved
  function automatic logic [6:0] rate_x2(input logic [2:0] code);
    unique case (code)
      3'h0:    rate_x2 = 7'h02;
      3'h1:    rate_x2 = 7'h03;
      3'h2:    rate_x2 = 7'h04;
      3'h3:    rate_x2 = 7'h06;
      3'h4:    rate_x2 = 7'h08;
      3'h5:    rate_x2 = 7'h0b;
      3'h6:    rate_x2 = 7'h0c;
      default: rate_x2 = 7'h00;
    endcase
  endfunction

  // bit clock code to ratio times two; top codes share /32
  function automatic logic [6:0] bclk_ratio_x2(input logic [3:0] code);
    unique case (code)
      4'h0:    bclk_ratio_x2 = 7'h02;
      4'h1:    bclk_ratio_x2 = 7'h03;
      4'h2:    bclk_ratio_x2 = 7'h04;
      4'h3:    bclk_ratio_x2 = 7'h06;
      4'h4:    bclk_ratio_x2 = 7'h08;
      4'h5:    bclk_ratio_x2 = 7'h0b;
      4'h6:    bclk_ratio_x2 = 7'h0c;
      4'h7:    bclk_ratio_x2 = 7'h10;
      4'h8:    bclk_ratio_x2 = 7'h16;
      4'h9:    bclk_ratio_x2 = 7'h18;
      4'ha:    bclk_ratio_x2 = 7'h20;
      4'hb:    bclk_ratio_x2 = 7'h2c;
      4'hc:    bclk_ratio_x2 = 7'h30;
      default: bclk_ratio_x2 = 7'h40;
    endcase
  endfunction

  // output clock code to ratio times two, zero for reserved
  function automatic logic [6:0] out_ratio_x2(input logic [2:0] code);
    unique case (code)
      3'h0:    out_ratio_x2 = 7'h02;
      3'h1:    out_ratio_x2 = 7'h04;
      3'h2:    out_ratio_x2 = 7'h06;
      3'h3:    out_ratio_x2 = 7'h08;
      3'h4:    out_ratio_x2 = 7'h0b;
      3'h5:    out_ratio_x2 = 7'h0c;
      default: out_ratio_x2 = 7'h00;
    endcase
  endfunction

  // ratio decode; reserved codes stop their divider
  assign adc_x2  = rate_x2(st_reg.adc_rate_div);
  assign dac_x2  = rate_x2(st_reg.dac_rate_div);
  assign bclk_x2 = st_reg.bitclk_master_en ? bclk_ratio_x2(st_reg.bclk_div) : 7'h00;
  assign out_x2  = out_ratio_x2(st_reg.outclk_div);

  frac_div u_adc_rate (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .run      (adc_x2 != 7'h00),
    .ratio_x2 (adc_x2),
    .tick     (adc_rate_tick),
    .level    ()
  );

  frac_div u_dac_rate (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .run      (dac_x2 != 7'h00),
    .ratio_x2 (dac_x2),
    .tick     (dac_rate_tick),
    .level    ()
  );

  frac_div u_bit_clock (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .run      (bclk_x2 != 7'h00),
    .ratio_x2 (bclk_x2),
    .tick     (bclk_gen_tick),
    .level    (bclk_gen_level)
  );

  frac_div u_out_clock (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .run      (out_x2 != 7'h00),
    .ratio_x2 (out_x2),
    .tick     (outclk_tick),
    .level    (out_level)
  );

  // bit clock source: own divider in master, host edges in slave
  assign slave_bit_tick = st_reg.bclk_sync[1] & ~st_reg.bclk_sync[2];
  assign bitclk_tick    = st_reg.bitclk_master_en ? bclk_gen_tick : slave_bit_tick;
  assign bitclk_pin_out = bclk_gen_level;
  assign bitclk_pin_oe  = st_reg.bitclk_master_en;
  assign adc_bit_clock  = bclk_gen_level;
  assign codec_out_clock = out_level;

  frame_gen u_adc_frame (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .gen_en    (st_reg.adc_frame_gen_en),
    .bit_tick  (bitclk_tick),
    .phase_len (st_reg.adc_frame_len),
    .frame_clk (adc_gen_clk)
  );

  frame_gen u_dac_frame (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .gen_en    (st_reg.dac_frame_gen_en),
    .bit_tick  (bitclk_tick),
    .phase_len (st_reg.dac_frame_len),
    .frame_clk (dac_gen_clk)
  );

  // frame clocks: generated, or taken from the host when generation is off
  assign adc_frame_clock = st_reg.adc_frame_gen_en ? adc_gen_clk : st_reg.adc_frame_sync[1];
  assign dac_frame_clock = st_reg.dac_frame_gen_en ? dac_gen_clk : st_reg.dac_frame_sync[1];
  assign frame_pin_out   = st_reg.frame_pin_src_sel ? adc_gen_clk : dac_gen_clk;
  assign frame_pin_oe    = st_reg.frame_pin_src_sel ? st_reg.adc_frame_gen_en
                                                    : st_reg.dac_frame_gen_en;

  // samples per period follow the clocking mode
  assign smp_len = (st_reg.clocking_mode_sel == clkdiv_pkg::MODE_USB) ? `SMP_LEN_USB
                                                                     : `SMP_LEN_NORMAL;
  assign adc_sample_tick = adc_rate_tick && (st_reg.adc_smp_cnt == smp_len - 9'h001);
  assign dac_sample_tick = dac_rate_tick && (st_reg.dac_smp_cnt == smp_len - 9'h001);

  // slow clock shared by debounce and zero-cross timeout
  // >= so a faster rate never waits for a full 21-bit counter wrap
  assign slow_limit = st_reg.slowclk_rate_sel ? 21'(SLOW_DIV_SHORT - 1)
                                              : 21'(SLOW_DIV_LONG - 1);
  assign slow_tick          = st_reg.slowclk_en && (st_reg.slow_cnt >= slow_limit);
  assign jack_debounce_tick = slow_tick;
  assign zc_timeout_tick    = slow_tick;
  assign reg_rdata          = st_reg.rdata;

  // registers, synchronisers and counters
  always_comb begin
    st_next = st_reg;
    // host pins: first flop feeds only the second
    st_next.bclk_sync      = {st_reg.bclk_sync[1:0], bitclk_pin_in};
    st_next.dac_frame_sync = {st_reg.dac_frame_sync[0], frame_pin_in};
    st_next.adc_frame_sync = {st_reg.adc_frame_sync[0], adc_frame_pin_in};
    if (adc_rate_tick) begin
      st_next.adc_smp_cnt = adc_sample_tick ? 9'h000 : st_reg.adc_smp_cnt + 9'h001;
    end
    if (dac_rate_tick) begin
      st_next.dac_smp_cnt = dac_sample_tick ? 9'h000 : st_reg.dac_smp_cnt + 9'h001;
    end
    if (!st_reg.slowclk_en || slow_tick) begin
      st_next.slow_cnt = 21'h000000;
    end else begin
      st_next.slow_cnt = st_reg.slow_cnt + 21'h000001;
    end
    // register writes; the slow clock enable lives in one flop behind two offsets
    if (reg_wr) begin
      unique case (reg_addr)
        `REG_POWER_MGMT_FOUR: st_next.slowclk_en = reg_wdata[`BIT_SLOWCLK_EN_PM4];
        `REG_CLOCK_CONTROL_ONE: begin
          st_next.slowclk_en       = reg_wdata[`BIT_SLOWCLK_EN_CC1];
          st_next.slowclk_rate_sel = reg_wdata[`BIT_SLOWCLK_RATE];
          st_next.bclk_div         = reg_wdata[`BCLK_DIV_MSB:`BCLK_DIV_LSB];
          st_next.outclk_div       = reg_wdata[`OUTCLK_DIV_MSB:0];
        end
        `REG_CLOCK_CONTROL_TWO: st_next.frame_pin_src_sel = reg_wdata[`BIT_FRAME_SRC_SEL];
        `REG_DAC_CONTROL: st_next.clocking_mode_sel =
          clkdiv_pkg::clk_mode_t'(reg_wdata[`BIT_CLOCKING_MODE]);
        `REG_DAC_FRAME_RATE: begin
          st_next.dac_frame_gen_en = reg_wdata[`BIT_FRAME_GEN_EN];
          st_next.dac_frame_len    = reg_wdata[`FRAME_LEN_MSB:0];
        end
        `REG_DAC_CLOCK_CONTROL: st_next.dac_rate_div = reg_wdata[`RATE_DIV_MSB:0];
        `REG_ADC_CLOCK_CONTROL: st_next.adc_rate_div = reg_wdata[`RATE_DIV_MSB:0];
        `REG_ADC_FRAME_RATE: begin
          st_next.adc_frame_gen_en = reg_wdata[`BIT_FRAME_GEN_EN];
          st_next.adc_frame_len    = reg_wdata[`FRAME_LEN_MSB:0];
        end
        `REG_AUDIO_IF_DAC_CTRL: st_next.bitclk_master_en = reg_wdata[`BIT_BITCLK_MASTER];
        default: ;
      endcase
    end
    // read data registered; unmapped offsets and other bits read zero
    if (reg_rd) begin
      st_next.rdata = 16'h0000;
      unique case (reg_addr)
        `REG_POWER_MGMT_FOUR: st_next.rdata[`BIT_SLOWCLK_EN_PM4] = st_reg.slowclk_en;
        `REG_CLOCK_CONTROL_ONE: begin
          st_next.rdata[`BIT_SLOWCLK_EN_CC1]           = st_reg.slowclk_en;
          st_next.rdata[`BIT_SLOWCLK_RATE]             = st_reg.slowclk_rate_sel;
          st_next.rdata[`BCLK_DIV_MSB:`BCLK_DIV_LSB]   = st_reg.bclk_div;
          st_next.rdata[`OUTCLK_DIV_MSB:0]             = st_reg.outclk_div;
        end
        `REG_CLOCK_CONTROL_TWO: st_next.rdata[`BIT_FRAME_SRC_SEL] = st_reg.frame_pin_src_sel;
        `REG_DAC_CONTROL: st_next.rdata[`BIT_CLOCKING_MODE] = st_reg.clocking_mode_sel;
        `REG_DAC_FRAME_RATE: begin
          st_next.rdata[`BIT_FRAME_GEN_EN]  = st_reg.dac_frame_gen_en;
          st_next.rdata[`FRAME_LEN_MSB:0]   = st_reg.dac_frame_len;
        end
        `REG_DAC_CLOCK_CONTROL: st_next.rdata[`RATE_DIV_MSB:0] = st_reg.dac_rate_div;
        `REG_ADC_CLOCK_CONTROL: st_next.rdata[`RATE_DIV_MSB:0] = st_reg.adc_rate_div;
        `REG_ADC_FRAME_RATE: begin
          st_next.rdata[`BIT_FRAME_GEN_EN]  = st_reg.adc_frame_gen_en;
          st_next.rdata[`FRAME_LEN_MSB:0]   = st_reg.adc_frame_len;
        end
        `REG_AUDIO_IF_DAC_CTRL: st_next.rdata[`BIT_BITCLK_MASTER] = st_reg.bitclk_master_en;
        default: ;
      endcase
    end
  end

  // reset leaves every mode off, divide by one and frame length 64
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg               <= '0;
      st_reg.adc_frame_len <= `FRAME_LEN_RST;
      st_reg.dac_frame_len <= `FRAME_LEN_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  a_master_pin_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && reg_addr == `REG_AUDIO_IF_DAC_CTRL) |=>
      bitclk_pin_oe == $past(reg_wdata[`BIT_BITCLK_MASTER]))
    else $error("bit clock pin enable does not follow the master bit");

  a_slow_alias: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && reg_addr == `REG_POWER_MGMT_FOUR) ##1 (reg_rd && reg_addr ==
      `REG_CLOCK_CONTROL_ONE && !reg_wr) |=>
      reg_rdata[`BIT_SLOWCLK_EN_CC1] == $past(reg_wdata[`BIT_SLOWCLK_EN_PM4], 2))
    else $error("slow clock enable differs between its two addresses");

  a_slow_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !st_reg.slowclk_en |-> !jack_debounce_tick && !zc_timeout_tick)
    else $error("slow clock ticked while disabled");

  a_frame_pin_src: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (frame_pin_oe && st_reg.frame_pin_src_sel) |-> frame_pin_out == adc_frame_clock)
    else $error("frame pin not carrying the adc frame clock");

  a_slave_frame_in: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!st_reg.dac_frame_gen_en && $stable(st_reg.dac_frame_gen_en)) ##0
      $rose(st_reg.dac_frame_sync[1]) |-> $rose(dac_frame_clock))
    else $error("slave dac frame clock does not follow the host");

  a_adc_div_two: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_reg.adc_rate_div == 3'h2 && !reg_wr && adc_rate_tick) ##1 !reg_wr
      |-> !adc_rate_tick ##1 adc_rate_tick)
    else $error("adc divide by two tick spacing wrong");

  a_slave_bit_edge: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!st_reg.bitclk_master_en && $rose(st_reg.bclk_sync[2])) |-> $past(bitclk_tick))
    else $error("slave bit clock edge not passed to the core");

  a_usb_sample: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (adc_sample_tick && st_reg.clocking_mode_sel == clkdiv_pkg::MODE_USB) |->
      st_reg.adc_smp_cnt == 9'h10f)
    else $error("usb mode sample period is not 272 rate cycles");
endmodule // audio_clock_divider_gen

// >>> dv/host_serial_model.sv
// host side of the audio serial link: slave bit clock and frame clocks
`timescale 1ns/100ps
module host_serial_model #(
  parameter int HALF_NS    = 350,
  parameter int PHASE_BITS = 8
) (
  // control
  input  wire logic run,
  // clocks towards the codec
  output logic      bclk,
  output logic      lrc,
  output logic      adc_lrc
);
  int cnt;
  // frames change on a falling bit clock edge, together, so they stay aligned
  initial begin
    bclk = 1'b0;
    lrc = 1'b0;
    adc_lrc = 1'b0;
    cnt = 0;
    #30;
    forever begin
      #(HALF_NS) bclk = run & ~bclk; // idle clock stands still low
      if (run && !bclk) begin
        cnt = cnt + 1;
        if (cnt == PHASE_BITS) begin
          cnt = 0;
          lrc = ~lrc;
          adc_lrc = ~adc_lrc;
        end
      end
    end
  end
endmodule // host_serial_model

// >>> dv/audio_clock_divider_gen_test.sv
// register-driven checks of the codec clock divider
`timescale 1ns/100ps
module audio_clock_divider_gen_test;
  logic clk_sys, sys_rst, reg_wr, reg_rd, run, bp, fp, ap, bo, boe, fo, foe, ab;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  wire  [12:0] s;
  time         t_wr = 0, t_rd = 0;
  int errors = 0, checks_done = 0;
  int bx2[16] = '{2, 3, 4, 6, 8, 11, 12, 16, 22, 24, 32, 44, 48, 64, 64, 64};
  int rx2[7] = '{2, 3, 4, 6, 8, 11, 12};
  int ox2[6] = '{2, 4, 6, 8, 11, 12};
  host_serial_model host (.run(run), .bclk(bp), .lrc(fp), .adc_lrc(ap));
  audio_clock_divider_gen #(.SLOW_DIV_LONG(64), .SLOW_DIV_SHORT(16)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bitclk_pin_in(bp),
    .bitclk_pin_out(bo), .bitclk_pin_oe(boe), .frame_pin_in(fp), .frame_pin_out(fo),
    .frame_pin_oe(foe), .adc_frame_pin_in(ap), .adc_bit_clock(ab),
    .codec_out_clock(s[11]), .bitclk_tick(s[2]), .adc_frame_clock(s[8]),
    .dac_frame_clock(s[7]), .adc_rate_tick(s[0]), .dac_rate_tick(s[1]),
    .adc_sample_tick(s[4]), .dac_sample_tick(s[12]), .outclk_tick(s[3]),
    .jack_debounce_tick(s[5]), .zc_timeout_tick(s[6]));
  assign s[9] = fo;
  assign s[10] = bo;
  // clock and reset
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // a strobe lowered in this time step lets one edge pass before it rises again
  task wr(input logic [7:0] a, input logic [15:0] d);
    if (t_wr == $time) @(negedge clk_sys);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge clk_sys) reg_wr = 1'b0;
    t_wr = $time;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    if (t_rd == $time) @(negedge clk_sys);
    reg_addr = a; reg_rd = 1'b1;
    @(negedge clk_sys) reg_rd = 1'b0;
    t_rd = $time;
    chk(reg_rdata, e);
  endtask
  // cycles over k periods; indices below 7 count when high, index 7 up (levels, and the tick at 12) on rise
  task gap(input int w, input int k, input int e);
    int n, c, t;
    logic p;
    n = 0; c = 0; t = 0; p = 1'b1;
    while (c < k + 1 && t < 3000) begin
      @(negedge clk_sys);
      t++;
      if (c > 0) n++;
      if (s[w] === 1'b1 && (w < 7 || p === 1'b0)) c++;
      p = s[w];
    end
    if (t >= 3000) begin
      errors++;
      conclude();
    end else begin
      chk(16'(n), 16'(e));
    end
  endtask
  initial begin
    sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; run = 1'b0;
    reg_addr = 8'h00; reg_wdata = 16'h0000;
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    rd(8'h35, 16'h0040);
    rd(8'h46, 16'h0040);
    rd(8'h73, 16'h0000);
    rd(8'h30, 16'h0000);
    rd(8'h50, 16'h0000);
    $display("registers done");
    for (int c = 0; c < 7; c++) begin
      wr(8'h44, 16'(c));
      wr(8'h36, 16'(6 - c));
      gap(0, 2, rx2[c]);
      gap(1, 2, rx2[6 - c]);
    end
    for (int c = 0; c < 6; c++) begin
      wr(8'h28, 16'(c));
      gap(3, 2, ox2[c]);
      if (c > 0) gap(11, 2, ox2[c]);
    end
    wr(8'h44, 16'h0000);
    gap(4, 1, 256);
    gap(12, 1, 256);
    wr(8'h30, 16'h1000);
    gap(4, 1, 272);
    gap(12, 1, 272);
    $display("rates done");
    wr(8'h0b, 16'h0100);
    rd(8'h28, 16'h8005);
    gap(5, 1, 64);
    gap(6, 1, 64);
    wr(8'h28, 16'hc000);
    gap(5, 1, 16);
    wr(8'h0b, 16'h0000);
    rd(8'h28, 16'h4000);
    $display("slow clock done");
    wr(8'h73, 16'h4000);
    for (int c = 0; c < 16; c++) begin
      wr(8'h28, 16'(c << 4));
      gap(2, 2, bx2[c]);
      chk({15'h0, boe}, 16'h0001);
      chk({15'h0, ab}, {15'h0, bo});
      if (c > 1) gap(10, 2, bx2[c]);
    end
    wr(8'h28, 16'h0000);
    wr(8'h35, 16'h0808);
    gap(7, 1, 16);
    gap(9, 1, 16);
    chk({15'h0, foe}, 16'h0001);
    wr(8'h46, 16'h0809);
    wr(8'h29, 16'h8000);
    gap(9, 1, 18);
    wr(8'h28, 16'h0020);
    gap(7, 1, 32);
    $display("master done");
    wr(8'h73, 16'h0000);
    wr(8'h35, 16'h0008);
    wr(8'h46, 16'h0008);
    run = 1'b1;
    chk({15'h0, boe}, 16'h0000);
    chk({15'h0, foe}, 16'h0000);
    gap(2, 1, 7);
    gap(7, 1, 112);
    gap(8, 1, 112);
    $display("slave done");
    conclude();
  end
endmodule // audio_clock_divider_gen_test
